// [logic/wsw_params.svh]
// Offsets, field positions, reset values and timing counts of the watchdog and sleep block.
`ifndef WSW_PARAMS_SVH
`define WSW_PARAMS_SVH

// Register indexes; the byte address on the bus is four times the index.
`define WSW_IDX_STATUS 14'h0003
`define WSW_IDX_INTCTL 14'h000b
`define WSW_IDX_PIRQF 14'h000c
`define WSW_IDX_OPTION 14'h0081
`define WSW_IDX_PIRQE 14'h008c
`define WSW_IDX_CONFIG 14'h2007

// Field positions in interrupt_control.
`define WSW_B_GIE 7
`define WSW_B_PERIPHERAL_IRQ_ENABLE 6
`define WSW_B_TIMER0_OVERFLOW_ENABLE 5
`define WSW_B_XIE 4
`define WSW_B_PCIE 3
`define WSW_B_TIMER0_OVERFLOW_FLAG 2
`define WSW_B_XIF 1
`define WSW_B_PCIF 0

// Field positions in the option, configuration and status registers.
`define WSW_B_EDGE 6
`define WSW_B_PSA 3
`define WSW_B_WATCHDOG_FUSE_ENABLE 3
`define WSW_B_TO 4
`define WSW_B_PD 3

// Reset values of the writable registers and implemented bits of the peripheral flag and enable registers.
`define WSW_RST_INTCTL 8'h00
`define WSW_RST_PIRQF 8'h00
`define WSW_RST_PIRQE 8'h00
`define WSW_RST_OPTION 8'hff
`define WSW_RST_CONFIG 8'hff
`define WSW_PIRQ_MASK 8'hc9

// Watchdog base period: 18 ms in microseconds, clock in MHz, count of clk_sys cycles.
`define WSW_WDT_BASE_US 18000
`define WSW_CLK_MHZ 40
`define WSW_WDT_BASE_CYC (`WSW_WDT_BASE_US * `WSW_CLK_MHZ)
`define WSW_BASE_W 24

// Fixed interrupt vector.
`define WSW_VECTOR 13'h0004

`endif

// [logic/wsw_pkg.sv]
// Types shared by the watchdog and sleep control modules.
`default_nettype none
`include "wsw_params.svh"
package wsw_pkg;

	typedef enum logic [0:0] {st_run, st_sleep} wsw_mode_e;

	typedef struct packed {
		logic [`WSW_BASE_W-1:0] base;
		logic [6:0] pre;
		logic pend;
	} wsw_wdt_s;

	typedef struct packed {
		wsw_mode_e mode;
		logic [2:0] master_clear_pin_n_s;
		logic master_clear_pin_n_f;
		logic [2:0] xirq_s;
		logic xirq_f;
		logic [7:0] intctl;
		logic [7:0] pirqf;
		logic [7:0] pirqe;
		logic [7:0] option;
		logic [7:0] config_w;
		logic to_n;
		logic pd_n;
		logic ack;
		logic [7:0] rdat;
		logic dev_rst;
		logic clr;
		logic vec;
		logic [12:0] prefetch;
		logic [12:0] ret;
	} wsw_top_s;

endpackage
`default_nettype wire

// [logic/wsw_wdt.sv]
// Watchdog counter with its optional power-of-two prescaler.
`default_nettype none
`include "wsw_params.svh"
module wsw_wdt
	import wsw_pkg::*;
#(
	parameter int BASE_CYC = `WSW_WDT_BASE_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic enable,
	input wire logic prescaler_assign,
	input wire logic [2:0] ps,
	input wire logic clear,
	output logic timeout
);

	wsw_wdt_s q, d;

	// Last prescaler count for the selected ratio 1:1 up to 1:128.
	function automatic logic [6:0] ratio_last(input logic [2:0] sel);
		ratio_last = 7'((8'h01 << sel) - 8'h01);
	endfunction

	// The counter free-runs on its own timebase, never gated by the core's sleep state.
	always_comb begin
		d = q;
		if (clear || !enable) begin
			d.base = '0;
			d.pre = '0;
			d.pend = 1'b0;
		end else begin
			d.pend = 1'b0;
			if (q.base == `WSW_BASE_W'(BASE_CYC - 1)) begin
				d.base = '0;
				if (!prescaler_assign || q.pre == ratio_last(ps)) begin
					d.pre = '0;
					d.pend = 1'b1;
				end else begin
					d.pre = q.pre + 7'h01;
				end
			end else begin
				d.base = q.base + `WSW_BASE_W'(1);
			end
		end
	end

	// State register.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// A clear in the cycle of the time-out suppresses it.
	assign timeout = q.pend && enable && !clear;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	wrap_to_timeout_a: assert property (d.pend && !clear |=> timeout || clear || !enable)
		else $error("time-out did not follow wrap by one cycle");
	clear_wins_a: assert property (clear |-> !timeout)
		else $error("time-out asserted while cleared");

endmodule
`default_nettype wire

// [logic/wsw_top.sv]
// Watchdog, sleep entry and wake-up control with its register file on a Wishbone slave.
`default_nettype none
`include "wsw_params.svh"
// How it works
// - Watchdog counts on its own free-running timebase, unaffected by sleep.
// - A watchdog time-out while running pulses the internal device reset.
// - A watchdog time-out while asleep wakes the core instead of resetting.
// - Configuration watchdog enable bit at zero stops the watchdog until the bit is written back to one.
// - Without prescaler the time-out is about 18 ms.
// - Option register can give the watchdog a prescaler up to 1:128.
// - Clear-watchdog and sleep instructions clear counter and assigned prescaler.
// - A watchdog time-out clears the active-low timeout flag unless master-clear ends sleep in the same cycle.
// - Sleep entry clears watchdog, clears powerdown, sets timeout, stops oscillator, holds pins.
// - A watchdog reset never drives the master-clear pin low.
// - Master-clear, watchdog time-out or enabled interrupt end sleep.
// - Powerdown flag sets at power-up and clears on the sleep instruction.
// - The address after the sleep instruction is prefetched.
// - Interrupt wake needs the individual enable, never the global enable.
// - After wake, global enable set means one instruction then the vector.
// - Enabled pending interrupt at sleep makes the core wake at once.
// - Every wake from sleep clears the watchdog.
// - Servicing clears global enable, pushes return address, loads vector.
// - Interrupt flags set on their events regardless of enables.
module wsw_top
	import wsw_pkg::*;
#(
	parameter int WDT_BASE_CYC = `WSW_WDT_BASE_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic master_clear_pin_n,
	input wire logic external_irq_pin,
	input wire logic timer0_overflow_evt,
	input wire logic port_change_evt,
	input wire logic [7:0] peripheral_evt,
	input wire logic watchdog_clear_instr,
	input wire logic sleep_instr,
	input wire logic instr_retire,
	input wire logic [12:0] pc_i,
	output logic core_run,
	output logic osc_driver_en,
	output logic io_hold,
	output logic device_reset,
	output logic [12:0] prefetch_addr,
	output logic vector_load,
	output logic [12:0] vector_addr,
	output logic return_push,
	output logic [12:0] return_addr,
	output logic timeout_flag_n,
	output logic powerdown_flag_n
);

	wsw_top_s q, d;
	logic wdt_to;
	logic wdt_clear;
	logic wake_req;
	logic req;
	logic wr;
	logic [13:0] idx;

	// The watchdog clears on either instruction directly and on wake or watchdog reset one cycle later.
	assign wdt_clear = watchdog_clear_instr || (sleep_instr && q.mode == st_run) || q.clr;

	wsw_wdt #(
		.BASE_CYC(WDT_BASE_CYC)
	) u_wdt (
		.clk_sys(clk_sys),
		.rst(rst),
		.enable(q.config_w[`WSW_B_WATCHDOG_FUSE_ENABLE]),
		.prescaler_assign(q.option[`WSW_B_PSA]),
		.ps(q.option[2:0]),
		.clear(wdt_clear),
		.timeout(wdt_to)
	);

	// An interrupt source wakes the core when its own enable and flag are both set; peripheral sources also need the group enable.
	assign wake_req = (q.intctl[`WSW_B_TIMER0_OVERFLOW_ENABLE] && q.intctl[`WSW_B_TIMER0_OVERFLOW_FLAG])
		|| (q.intctl[`WSW_B_XIE] && q.intctl[`WSW_B_XIF])
		|| (q.intctl[`WSW_B_PCIE] && q.intctl[`WSW_B_PCIF])
		|| (q.intctl[`WSW_B_PERIPHERAL_IRQ_ENABLE] && |(q.pirqe & q.pirqf));

	// Bus decode: a new request is one not yet answered; a write lands on the ack edge.
	assign req = wb_cyc_i && wb_stb_i && !q.ack;
	assign wr = wb_cyc_i && wb_stb_i && q.ack && wb_we_i && wb_sel_i[0];
	assign idx = wb_adr_i[15:2];

	// Next-state logic for the whole block.
	always_comb begin
		d = q;
		d.ack = 1'b0;
		d.dev_rst = 1'b0;
		d.clr = 1'b0;
		d.vec = 1'b0;

		// Pins pass three flops; a level counts once the last two agree.
		d.master_clear_pin_n_s = {q.master_clear_pin_n_s[1:0], master_clear_pin_n};
		d.xirq_s = {q.xirq_s[1:0], external_irq_pin};
		if (q.master_clear_pin_n_s[2] == q.master_clear_pin_n_s[1]) begin
			d.master_clear_pin_n_f = q.master_clear_pin_n_s[2];
		end
		if (q.xirq_s[2] == q.xirq_s[1]) begin
			d.xirq_f = q.xirq_s[2];
		end

		// Software writes first, so hardware events below win over a clear.
		if (wr) begin
			case (idx)
				`WSW_IDX_INTCTL: d.intctl = wb_dat_i[7:0];
				`WSW_IDX_PIRQF: d.pirqf = wb_dat_i[7:0] & `WSW_PIRQ_MASK;
				`WSW_IDX_PIRQE: d.pirqe = wb_dat_i[7:0] & `WSW_PIRQ_MASK;
				`WSW_IDX_OPTION: d.option = wb_dat_i[7:0];
				`WSW_IDX_CONFIG: d.config_w = wb_dat_i[7:0];
				default: ;
			endcase
		end

		// Flags set on their events whatever the enables say.
		if (timer0_overflow_evt) begin
			d.intctl[`WSW_B_TIMER0_OVERFLOW_FLAG] = 1'b1;
		end
		if (port_change_evt) begin
			d.intctl[`WSW_B_PCIF] = 1'b1;
		end
		if (d.xirq_f != q.xirq_f && d.xirq_f == q.option[`WSW_B_EDGE]) begin
			d.intctl[`WSW_B_XIF] = 1'b1;
		end
		d.pirqf = d.pirqf | (peripheral_evt & `WSW_PIRQ_MASK);

		// Sleep, wake and reset sequencing.
		case (q.mode)
			st_run: begin
				if (sleep_instr) begin
					d.pd_n = 1'b0;
					d.to_n = 1'b1;
					d.prefetch = pc_i + 13'h0001;
					if (wake_req) begin
						d.clr = 1'b1;
					end else begin
						d.mode = st_sleep;
					end
				end else if (watchdog_clear_instr) begin
					d.pd_n = 1'b1;
					d.to_n = 1'b1;
				end
				if (wdt_to) begin
					d.to_n = 1'b0;
					d.dev_rst = 1'b1;
					d.clr = 1'b1;
				end else if (instr_retire && q.intctl[`WSW_B_GIE] && wake_req && !sleep_instr) begin
					d.vec = 1'b1;
					d.intctl[`WSW_B_GIE] = 1'b0;
					d.ret = pc_i;
				end
			end
			st_sleep: begin
				if (!q.master_clear_pin_n_f) begin
					d.mode = st_run;
					d.clr = 1'b1;
				end else if (wdt_to) begin
					d.to_n = 1'b0;
					d.mode = st_run;
					d.clr = 1'b1;
				end else if (wake_req) begin
					d.mode = st_run;
					d.clr = 1'b1;
				end
			end
			default: d.mode = st_run;
		endcase

		// Master-clear resets the core in any state and stays internal only for the watchdog.
		if (!q.master_clear_pin_n_f) begin
			d.dev_rst = 1'b1;
		end

		// Read data is captured with the request and shown with ack.
		if (req) begin
			d.ack = 1'b1;
			case (idx)
				`WSW_IDX_STATUS: d.rdat = {3'h0, q.to_n, q.pd_n, 3'h0};
				`WSW_IDX_INTCTL: d.rdat = q.intctl;
				`WSW_IDX_PIRQF: d.rdat = q.pirqf;
				`WSW_IDX_PIRQE: d.rdat = q.pirqe;
				`WSW_IDX_OPTION: d.rdat = q.option;
				`WSW_IDX_CONFIG: d.rdat = q.config_w;
				default: d.rdat = 8'h00;
			endcase
		end
	end

	// State register; power-up sets both status flags.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			q <= '0;
			q.mode <= st_run;
			q.master_clear_pin_n_s <= 3'h7;
			q.master_clear_pin_n_f <= 1'b1;
			q.intctl <= `WSW_RST_INTCTL;
			q.pirqf <= `WSW_RST_PIRQF;
			q.pirqe <= `WSW_RST_PIRQE;
			q.option <= `WSW_RST_OPTION;
			q.config_w <= `WSW_RST_CONFIG;
			q.to_n <= 1'b1;
			q.pd_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Outputs; while asleep the oscillator driver is off and pins keep their state.
	assign core_run = (q.mode == st_run);
	assign osc_driver_en = core_run;
	assign io_hold = !core_run;
	assign device_reset = q.dev_rst;
	assign prefetch_addr = q.prefetch;
	assign vector_load = q.vec;
	assign vector_addr = `WSW_VECTOR;
	assign return_push = q.vec;
	assign return_addr = q.ret;
	assign timeout_flag_n = q.to_n;
	assign powerdown_flag_n = q.pd_n;
	assign wb_ack_o = q.ack;
	assign wb_dat_o = {24'h000000, q.rdat};

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	wdt_reset_a: assert property (q.mode == st_run && wdt_to |=> device_reset && !timeout_flag_n)
		else $error("run time-out gave no reset");
	sleep_wake_a: assert property (q.mode == st_sleep && wdt_to && q.master_clear_pin_n_f
		|=> core_run && !device_reset && !timeout_flag_n)
		else $error("sleep time-out did not wake cleanly");
	fuse_off_a: assert property (!q.config_w[`WSW_B_WATCHDOG_FUSE_ENABLE] |-> !wdt_to)
		else $error("disabled watchdog timed out");
	sleep_flags_a: assert property (core_run && sleep_instr && !wdt_to
		|=> !powerdown_flag_n && timeout_flag_n)
		else $error("sleep entry flags wrong");
	wake_clears_a: assert property (q.mode == st_sleep ##1 q.mode == st_run |-> q.clr)
		else $error("wake did not clear watchdog");
	irq_wake_a: assert property (q.mode == st_sleep && wake_req && q.master_clear_pin_n_f && !wdt_to
		|=> core_run && !device_reset)
		else $error("enabled interrupt did not wake");
	early_wake_a: assert property (core_run && sleep_instr && wake_req |=> core_run)
		else $error("pending interrupt let core sleep");
	vector_a: assert property (vector_load |-> vector_addr == `WSW_VECTOR
		&& !q.intctl[`WSW_B_GIE] && return_push)
		else $error("vector service wrong");
	prefetch_a: assert property (core_run && sleep_instr
		|=> prefetch_addr == 13'($past(pc_i) + 13'h0001))
		else $error("prefetch address wrong");
	flag_set_a: assert property (timer0_overflow_evt |=> q.intctl[`WSW_B_TIMER0_OVERFLOW_FLAG])
		else $error("event flag not set");
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");

	sleep_cov: cover property (core_run && sleep_instr ##1 q.mode == st_sleep);
	wdt_wake_cov: cover property (q.mode == st_sleep && wdt_to);
	irq_vec_cov: cover property (q.mode == st_sleep ##1 core_run ##[1:20] vector_load);
	wdt_rst_cov: cover property (core_run && wdt_to);

endmodule
`default_nettype wire

// [dv/tb_watchdog_sleep_wake_control.sv]
// Self-checking bench for the watchdog, sleep and wake-up block.
`default_nettype none
`include "wsw_params.svh"
`define CHK(a, b) begin \
	tests_run++; \
	if ((a) !== (b)) begin \
		errors++; \
		$display("wrong value at %0t: %h versus %h", $time, a, b); \
	end \
end
module tb_watchdog_sleep_wake_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WDT = 20;
	logic clk_sys, rst, cyc, stb, we, master_clear_pin_n_n, xpin, t0_e, pc_e, clr_i, slp_i, ret_i, ack;
	logic core_run, osc_en, io_hold, dev_rst, vld, pushv, to_n, pd_n;
	logic [15:0] adr;
	logic [3:0] sel;
	logic [31:0] dat_i, dat_o;
	logic [7:0] pevt, q, r;
	logic [12:0] pc, p, pfa, vaddr, raddr;
	int errors, tests_run, seed, n_rst, n_vec, c, k, m;

	// Short base period keeps every watchdog interval up to 1:8 within a few hundred cycles.
	wsw_top #(.WDT_BASE_CYC(WDT)) dut_u (
		.clk_sys(clk_sys),
		.rst(rst),
		.wb_cyc_i(cyc),
		.wb_stb_i(stb),
		.wb_we_i(we),
		.wb_adr_i(adr),
		.wb_sel_i(sel),
		.wb_dat_i(dat_i),
		.wb_dat_o(dat_o),
		.wb_ack_o(ack),
		.master_clear_pin_n(master_clear_pin_n_n),
		.external_irq_pin(xpin),
		.timer0_overflow_evt(t0_e),
		.port_change_evt(pc_e),
		.peripheral_evt(pevt),
		.watchdog_clear_instr(clr_i),
		.sleep_instr(slp_i),
		.instr_retire(ret_i),
		.pc_i(pc),
		.core_run(core_run),
		.osc_driver_en(osc_en),
		.io_hold(io_hold),
		.device_reset(dev_rst),
		.prefetch_addr(pfa),
		.vector_load(vld),
		.vector_addr(vaddr),
		.return_push(pushv),
		.return_addr(raddr),
		.timeout_flag_n(to_n),
		.powerdown_flag_n(pd_n)
	);

	// Free-running 40 MHz system clock.
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Counts cycles of internal reset and of vector loads.
	always @(posedge clk_sys) begin
		if (dev_rst === 1'b1) n_rst++;
		if (vld === 1'b1) n_vec++;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop;
		$display("comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// One classic bus cycle; the request stands until ack is sampled high.
	task automatic bus(input logic w, input logic [13:0] idx, input logic [7:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		sel <= s;
		dat_i <= {24'h000000, d};
		do begin
			@(posedge clk_sys);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) errors++;
		q = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr(input logic [13:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d, 4'h1);
	endtask

	task automatic rd(input logic [13:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00, 4'hf);
		`CHK(q, e)
	endtask

	// One-cycle core strobes: bit0 timer0, bit1 port, bit2 clear, bit3 retire, bit4 sleep.
	task automatic ev(input logic [4:0] s, input logic [7:0] pe, input logic [12:0] a);
		@(posedge clk_sys);
		{slp_i, ret_i, clr_i, pc_e, t0_e} <= s;
		pevt <= pe;
		pc <= a;
		@(posedge clk_sys);
		{slp_i, ret_i, clr_i, pc_e, t0_e} <= 5'h00;
		pevt <= 8'h00;
		#1;
	endtask

	// Waits for core_run (w=0) or device_reset (w=1), counting cycles in c.
	task automatic wait_for(input logic w, input int lim);
		c = 0;
		while ((w ? dev_rst : core_run) !== 1'b1 && c < lim) begin
			@(posedge clk_sys);
			#1;
			c++;
		end
	endtask

	// Accepts a watchdog interval close to its nominal cycle count.
	function automatic logic in_win(input int got, input int n);
		return logic'(got >= n - 3 && got <= n + 4);
	endfunction

	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		report_and_stop();
	end

	// Main sequence.
	initial begin
		seed = 32'h36ef;
		{rst, master_clear_pin_n_n} = 2'b11;
		{cyc, stb, we, xpin, t0_e, pc_e, clr_i, slp_i, ret_i} = 9'h000;
		{adr, sel, dat_i, pevt, pc} = '0;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		`CHK({core_run, io_hold, osc_en, dev_rst}, 4'b1010)
		`CHK({to_n, pd_n}, 2'b11)
		rd(`WSW_IDX_STATUS, 8'h18);
		rd(`WSW_IDX_OPTION, 8'hff);
		rd(`WSW_IDX_CONFIG, 8'hff);
		rd(`WSW_IDX_INTCTL, 8'h00);
		rd(`WSW_IDX_PIRQF, 8'h00);
		rd(`WSW_IDX_PIRQE, 8'h00);
		rd(14'h0100, 8'h00);
		// Register access: disabled lane, read-only status, random contents.
		wr(`WSW_IDX_CONFIG, 8'hf7);
		bus(1'b1, `WSW_IDX_PIRQE, 8'hff, 4'h0);
		rd(`WSW_IDX_PIRQE, 8'h00);
		wr(`WSW_IDX_STATUS, 8'h00);
		rd(`WSW_IDX_STATUS, 8'h18);
		r = 8'($random(seed));
		wr(`WSW_IDX_PIRQE, r);
		rd(`WSW_IDX_PIRQE, r & `WSW_PIRQ_MASK);
		r = 8'($random(seed));
		wr(`WSW_IDX_INTCTL, r);
		rd(`WSW_IDX_INTCTL, r);
		// Flags set on events whatever the enables.
		wr(`WSW_IDX_INTCTL, 8'h00);
		wr(`WSW_IDX_PIRQF, 8'h00);
		r = 8'($random(seed));
		ev(5'h03, r, 13'h0000);
		@(posedge clk_sys);
		xpin <= 1'b1;
		ev(5'h00, 8'h00, 13'h0000);
		repeat (6) @(posedge clk_sys);
		rd(`WSW_IDX_PIRQF, r & `WSW_PIRQ_MASK);
		rd(`WSW_IDX_INTCTL, 8'h07);
		// Sleep entry, disabled source ignored, enabled source wakes, no vector.
		wr(`WSW_IDX_INTCTL, 8'h20);
		p = 13'($random(seed));
		ev(5'h10, 8'h00, p);
		`CHK({core_run, io_hold, osc_en, pd_n, to_n}, 5'b01001)
		`CHK(pfa, p + 13'h0001)
		ev(5'h02, 8'h00, p);
		repeat (30) @(posedge clk_sys);
		`CHK(core_run, 1'b0)
		ev(5'h01, 8'h00, p);
		wait_for(1'b0, 5);
		`CHK(core_run, 1'b1)
		k = n_vec;
		ev(5'h08, 8'h00, p + 13'h0001);
		@(posedge clk_sys);
		`CHK(n_vec, k)
		// Global enable set: wake, one instruction, then the vector.
		wr(`WSW_IDX_INTCTL, 8'ha0);
		p = 13'($random(seed));
		ev(5'h10, 8'h00, p);
		ev(5'h01, 8'h00, p);
		wait_for(1'b0, 5);
		`CHK(core_run, 1'b1)
		ev(5'h08, 8'h00, p + 13'h0001);
		`CHK({vld, pushv, vaddr}, {2'b11, 13'h0004})
		`CHK(raddr, p + 13'h0001)
		rd(`WSW_IDX_INTCTL, 8'h24);
		// Pending enabled flag at sleep wakes at once.
		ev(5'h10, 8'h00, p);
		wait_for(1'b0, 4);
		`CHK({core_run, pd_n}, 2'b10)
		// Peripheral source wakes through its own and the group enable.
		wr(`WSW_IDX_INTCTL, 8'h40);
		wr(`WSW_IDX_PIRQE, 8'h01);
		wr(`WSW_IDX_PIRQF, 8'h00);
		ev(5'h10, 8'h00, p);
		ev(5'h00, 8'h01, p);
		wait_for(1'b0, 5);
		`CHK(core_run, 1'b1)
		// Master-clear ends sleep with a device reset.
		wr(`WSW_IDX_INTCTL, 8'h00);
		ev(5'h10, 8'h00, p);
		@(posedge clk_sys);
		master_clear_pin_n_n <= 1'b0;
		wait_for(1'b1, 8);
		`CHK(dev_rst, 1'b1)
		@(posedge clk_sys);
		master_clear_pin_n_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		`CHK(core_run, 1'b1)
		// Watchdog on, prescaler not assigned: regular clears hold it off.
		wr(`WSW_IDX_CONFIG, 8'hff);
		wr(`WSW_IDX_OPTION, 8'hf7);
		k = n_rst;
		repeat (10) begin
			ev(5'h04, 8'h00, p);
			repeat (10) @(posedge clk_sys);
		end
		`CHK(n_rst, k)
		`CHK(to_n, 1'b1)
		// Time-out in sleep wakes without reset; run time-out resets.
		ev(5'h10, 8'h00, p);
		wait_for(1'b0, 60);
		`CHK(in_win(c, WDT), 1'b1)
		`CHK({n_rst, to_n}, {k, 1'b0})
		wait_for(1'b1, 60);
		`CHK(in_win(c, WDT), 1'b1)
		`CHK(to_n, 1'b0)
		for (m = 1; m < 4; m++) begin
			wr(`WSW_IDX_OPTION, 8'hf8 | 8'(m));
			ev(5'h04, 8'h00, p);
			`CHK(to_n, 1'b1)
			wait_for(1'b1, 250);
			`CHK(in_win(c, WDT << m), 1'b1)
			`CHK({dev_rst, to_n, core_run}, 3'b101)
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
